// file: shared/dam_consts.svh
// What this block does
// R1: idle counter at 63 sets idle flag
// R2: idle declaration raises change-of-idle interrupt
// R3: idle flag clears when counter returns to zero
// R4: both x-bits zero declares far-end failure
// R5: far-end failure flag held while condition persists
// R6: far-end failure change sets interrupt bit
// R7: x-bits back to one clear far-end failure
// R8: remote sends 111 when error free
// R9: far_end_block_error code 111 counts nothing
// R10: other far_end_block_error codes increment event counter
// R11: app ident bit: 1 c-bit, 0 m13
// R12: last app ident bit shown at bit 3
// R13: app ident change sets interrupt bit 2
// R14: idle frame needs valid, cp zero, x one, 1100
// R15: idle counter up on idle, down otherwise
// R16: status clears on read; far_end_block_error code shown
`ifndef DAM_CONSTS_SVH
`define DAM_CONSTS_SVH

// register indices; byte address is four times the index
`define DAM_IDX_CFG 7'h10
`define DAM_IDX_STAT 7'h11
`define DAM_IDX_INT 7'h13
`define DAM_IDX_MASK 7'h1A
`define DAM_IDX_CNT_HI 7'h58
`define DAM_IDX_CNT_LO 7'h59

// field positions
`define DAM_CFG_IDLE_BIT 5
`define DAM_STAT_FAR_END_RECEIVE_FAILURE_BIT 4
`define DAM_STAT_AIC_BIT 3
`define DAM_INT_IDLE_BIT 4
`define DAM_INT_FAR_END_RECEIVE_FAILURE_BIT 3
`define DAM_INT_AIC_BIT 2
`define DAM_INT_USED 8'h1C

// counter limits and reset values
`define DAM_IDLE_DECLARE 6'h3F
`define DAM_IDLE_ZERO 6'h00
`define DAM_FAR_END_BLOCK_ERROR_CLEAN 3'h7
`define DAM_CNT_MAX 16'hFFFF
`define DAM_CFG_RESET 4'h0
`define DAM_MASK_RESET 8'h00

`endif

// file: shared/dam_pkg.sv
package dam_pkg;

    // whole block state, registered in one place
    typedef struct packed {
        logic [5:0] idle_cnt;
        logic idle_flag;
        logic far_end_receive_failure_flag;
        logic aic_copy;
        logic [2:0] far_end_block_error_code;
        logic [3:0] cfg_ctl;
        logic [7:0] int_stat;
        logic [7:0] int_mask;
        logic [15:0] far_end_block_error_cnt;
        logic [7:0] cnt_lo_hold;
        logic ack;
        logic [31:0] dat;
        logic irq;
    } dam_state_t;

endpackage : dam_pkg

// file: rtl/dam_rx_alarm_monitor.sv
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "dam_consts.svh"

// register map, word index on the bus (byte address is four times the index):
//   0x10 config and alarm status: bit 5 idle flag, read only; bits 3:0 stored
//        control bits that steer nothing inside this block
//   0x11 alarm status: bit 4 far-end failure, bit 3 app ident copy,
//        bits 2:0 last far-end block error code
//   0x13 interrupt status: bit 4 idle change, bit 3 far-end change,
//        bit 2 app ident change; any read clears it, as does writing ones
//   0x1A interrupt mask, same layout, only the three used bits store
//   0x58 event counter high byte; the read snapshots the low byte and clears
//   0x59 event counter low byte as held by the last high-byte read
// limitation: software must read 0x58 before 0x59, or it sees a stale low byte
// trade-off: the counter saturates instead of wrapping, so a long outage
// reads as a full count rather than a small misleading one

module dam_rx_alarm_monitor (
    input wire logic clock,
    input wire logic reset,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [8:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    // one summary per received m-frame from the framer
    input wire logic frame_strobe,
    input wire logic frame_mfp_valid,
    input wire logic [2:0] frame_cp_bits,
    input wire logic [1:0] frame_x_bits,
    input wire logic frame_payload_1100,
    input wire logic [2:0] frame_far_end_block_error_bits,
    input wire logic frame_aic_bit,
    // alarm levels for the transmit side
    output logic idle_condition_flag,
    output logic far_end_fail_flag
);

    dam_pkg::dam_state_t st_r;
    dam_pkg::dam_state_t st_nxt;

    logic bus_req;
    logic [6:0] bus_idx;
    logic frame_is_idle;
    logic cnt_read;
    logic [7:0] int_set;

    assign bus_req = wb_cyc_i && wb_stb_i && !st_r.ack;
    assign bus_idx = wb_adr_i[8:2];
    // idle m-frame qualification [R14]
    assign frame_is_idle = frame_mfp_valid && (frame_cp_bits == 3'h0)
        && (frame_x_bits == 2'h3) && frame_payload_1100;
    // reading the high byte snapshots and clears the event counter
    assign cnt_read = bus_req && !wb_we_i && (bus_idx == `DAM_IDX_CNT_HI);

    // next-state logic: frame processing, then bus side effects
    always_comb
    begin
        st_nxt = st_r;
        int_set = 8'h00;

        if (frame_strobe)
        begin
            // up/down counter, floored at zero, capped at the declare level [R15]
            if (frame_is_idle)
            begin
                if (st_r.idle_cnt != `DAM_IDLE_DECLARE)
                    st_nxt.idle_cnt = st_r.idle_cnt + 6'h01;
            end
            else if (st_r.idle_cnt != `DAM_IDLE_ZERO)
            begin
                st_nxt.idle_cnt = st_r.idle_cnt - 6'h01;
            end
            if (st_nxt.idle_cnt == `DAM_IDLE_DECLARE)
                st_nxt.idle_flag = 1'b1; // [R1]
            else if (st_nxt.idle_cnt == `DAM_IDLE_ZERO)
                st_nxt.idle_flag = 1'b0; // [R3]

            // mixed x-bits leave the far-end state as it was
            if (frame_x_bits == 2'h0)
                st_nxt.far_end_receive_failure_flag = 1'b1; // [R4] [R5]
            else if (frame_x_bits == 2'h3)
                st_nxt.far_end_receive_failure_flag = 1'b0; // [R7]

            // 111 means the far end saw no parity errors [R8] [R9]
            st_nxt.far_end_block_error_code = frame_far_end_block_error_bits; // [R16]
            if (frame_far_end_block_error_bits != `DAM_FAR_END_BLOCK_ERROR_CLEAN && st_r.far_end_block_error_cnt != `DAM_CNT_MAX)
                st_nxt.far_end_block_error_cnt = st_r.far_end_block_error_cnt + 16'h0001; // [R10]

            // 1 marks c-bit parity framing, 0 marks m13 [R11]
            st_nxt.aic_copy = frame_aic_bit; // [R12]
            int_set[`DAM_INT_AIC_BIT] = frame_aic_bit != st_r.aic_copy; // [R13]
        end

        // both edges of each condition are change events
        int_set[`DAM_INT_IDLE_BIT] = st_nxt.idle_flag != st_r.idle_flag; // [R2]
        int_set[`DAM_INT_FAR_END_RECEIVE_FAILURE_BIT] = st_nxt.far_end_receive_failure_flag != st_r.far_end_receive_failure_flag; // [R6]

        // bus: one answer per request, ack falls in the following cycle
        st_nxt.ack = bus_req;
        st_nxt.dat = 32'h0000_0000;
        if (bus_req && wb_we_i)
        begin
            if (wb_sel_i[0])
            begin
                case (bus_idx)
                    `DAM_IDX_CFG: st_nxt.cfg_ctl = wb_dat_i[3:0];
                    `DAM_IDX_INT: st_nxt.int_stat = st_r.int_stat & ~wb_dat_i[7:0];
                    `DAM_IDX_MASK: st_nxt.int_mask = wb_dat_i[7:0] & `DAM_INT_USED;
                    default: st_nxt.cfg_ctl = st_r.cfg_ctl;
                endcase
            end
        end
        else if (bus_req)
        begin
            case (bus_idx)
                `DAM_IDX_CFG: st_nxt.dat = {24'h00_0000, 2'h0, st_r.idle_flag, 1'b0,
                    st_r.cfg_ctl};
                `DAM_IDX_STAT: st_nxt.dat = {24'h00_0000, 3'h0, st_r.far_end_receive_failure_flag,
                    st_r.aic_copy, st_r.far_end_block_error_code};
                `DAM_IDX_INT:
                begin
                    st_nxt.dat = {24'h00_0000, st_r.int_stat};
                    st_nxt.int_stat = 8'h00; // reset upon read [R16]
                end
                `DAM_IDX_MASK: st_nxt.dat = {24'h00_0000, st_r.int_mask};
                `DAM_IDX_CNT_HI:
                begin
                    st_nxt.dat = {24'h00_0000, st_r.far_end_block_error_cnt[15:8]};
                    st_nxt.cnt_lo_hold = st_r.far_end_block_error_cnt[7:0];
                end
                `DAM_IDX_CNT_LO: st_nxt.dat = {24'h00_0000, st_r.cnt_lo_hold};
                default: st_nxt.dat = 32'h0000_0000;
            endcase
        end

        // a frame error arriving with the read is kept, not lost
        if (cnt_read)
            st_nxt.far_end_block_error_cnt = (frame_strobe && frame_far_end_block_error_bits != `DAM_FAR_END_BLOCK_ERROR_CLEAN)
                ? 16'h0001 : 16'h0000; // [R10]

        // new events win over a clear in the same cycle
        st_nxt.int_stat = st_nxt.int_stat | int_set;
        st_nxt.irq = |(st_nxt.int_stat & st_nxt.int_mask);
    end

    // single state register
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            st_r <= '{idle_cnt: `DAM_IDLE_ZERO, cfg_ctl: `DAM_CFG_RESET,
                int_mask: `DAM_MASK_RESET, default: '0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_o = st_r.dat;
    assign wb_ack_o = st_r.ack;
    assign irq = st_r.irq;
    assign idle_condition_flag = st_r.idle_flag;
    assign far_end_fail_flag = st_r.far_end_receive_failure_flag;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_idle_declare_at63: assert property ( // [R1]
        frame_strobe && frame_is_idle && st_r.idle_cnt == 6'h3E |=> st_r.idle_flag)
        else $error("idle not declared at count 63");
    a_idle_clear_zero: assert property ( // [R3]
        frame_strobe && !frame_is_idle && st_r.idle_cnt == 6'h01 |=> !st_r.idle_flag)
        else $error("idle not cleared at count 0");
    a_idle_irq_set: assert property ( // [R2]
        $rose(st_r.idle_flag) |-> st_r.int_stat[4])
        else $error("idle change interrupt missing");
    a_far_end_receive_failure_declare: assert property ( // [R4]
        frame_strobe && frame_x_bits == 2'h0 |=> st_r.far_end_receive_failure_flag)
        else $error("far-end failure not declared");
    a_far_end_receive_failure_hold: assert property ( // [R5]
        !frame_strobe |=> $stable(st_r.far_end_receive_failure_flag))
        else $error("far-end failure flag moved without a frame");
    a_far_end_receive_failure_clear: assert property ( // [R7]
        frame_strobe && frame_x_bits == 2'h3 |=> !st_r.far_end_receive_failure_flag)
        else $error("far-end failure not cleared");
    a_far_end_receive_failure_irq_set: assert property ( // [R6]
        $changed(st_r.far_end_receive_failure_flag) |-> st_r.int_stat[3])
        else $error("far-end failure interrupt missing");
    a_far_end_block_error_counts_up: assert property ( // [R10]
        frame_strobe && frame_far_end_block_error_bits != 3'h7 && !cnt_read && st_r.far_end_block_error_cnt != 16'hFFFF
        |=> st_r.far_end_block_error_cnt == $past(st_r.far_end_block_error_cnt) + 16'h0001)
        else $error("far_end_block_error event not counted");
    a_far_end_block_error_clean_quiet: assert property ( // [R9]
        frame_strobe && frame_far_end_block_error_bits == 3'h7 && !cnt_read |=> $stable(st_r.far_end_block_error_cnt))
        else $error("clean far_end_block_error code counted");
    a_aic_copy_bit: assert property ( // [R12]
        frame_strobe |=> st_r.aic_copy == $past(frame_aic_bit)
        && st_r.far_end_block_error_code == $past(frame_far_end_block_error_bits))
        else $error("app ident copy wrong");
    a_aic_irq_set: assert property ( // [R13]
        frame_strobe && frame_aic_bit != st_r.aic_copy |=> st_r.int_stat[2])
        else $error("app ident change interrupt missing");
    a_int_read_clears: assert property ( // [R16]
        bus_req && !wb_we_i && bus_idx == 7'h13 && !frame_strobe
        |=> wb_ack_o && st_r.int_stat == 8'h00 ##1 !wb_ack_o)
        else $error("interrupt status not cleared on read");

    // bus handshake: exactly one answer, one cycle after the request is taken
    a_bus_ack_next: assert property (
        bus_req |=> wb_ack_o)
        else $error("bus request not answered");

    a_bus_ack_pulse: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held longer than one cycle");

    // read data is zero outside the answer so stale values never leak
    a_bus_dat_quiet: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data driven without ack");

    // a write with the low byte lane off must store nothing
    a_sel_low_ignored: assert property (
        bus_req && wb_we_i && !wb_sel_i[0] && bus_idx == `DAM_IDX_MASK
        |=> $stable(st_r.int_mask))
        else $error("mask stored with byte lane off");

    a_cfg_write_lands: assert property (
        bus_req && wb_we_i && wb_sel_i[0] && bus_idx == `DAM_IDX_CFG
        |=> st_r.cfg_ctl == $past(wb_dat_i[3:0]))
        else $error("config write lost");

    // idle counter moves only on frames and only by one step
    a_idle_cnt_up: assert property ( // [R15]
        frame_strobe && frame_is_idle && st_r.idle_cnt != 6'h3F
        |=> st_r.idle_cnt == $past(st_r.idle_cnt) + 6'h01)
        else $error("idle frame not counted up");

    a_idle_cnt_floor: assert property ( // [R15]
        frame_strobe && !frame_is_idle && st_r.idle_cnt == 6'h00
        |=> st_r.idle_cnt == 6'h00)
        else $error("idle counter went below zero");

    // a frame failing any idle test must never count up
    a_idle_needs_all: assert property ( // [R14]
        frame_strobe && !frame_is_idle
        |=> st_r.idle_cnt != $past(st_r.idle_cnt) + 6'h01)
        else $error("non-idle frame counted as idle");

    a_idle_flag_hold: assert property ( // [R15]
        !frame_strobe |=> $stable(st_r.idle_flag))
        else $error("idle flag moved without a frame");

    // clearing the idle condition is a change event as well
    a_idle_irq_clear: assert property ( // [R2]
        $fell(st_r.idle_flag) |-> st_r.int_stat[4])
        else $error("idle clear interrupt missing");

    // mixed x-bits are neither a declaration nor a clear
    a_far_end_receive_failure_mixed_hold: assert property ( // [R5]
        frame_strobe && (frame_x_bits == 2'h1 || frame_x_bits == 2'h2)
        |=> $stable(st_r.far_end_receive_failure_flag))
        else $error("mixed x-bits changed far-end state");

    // an unchanged app ident bit raises nothing
    a_aic_same_quiet: assert property ( // [R13]
        frame_strobe && frame_aic_bit == st_r.aic_copy && !st_r.int_stat[2]
        |=> !st_r.int_stat[2])
        else $error("app ident interrupt without change");

    // the counter pins at its ceiling instead of wrapping to a small value
    a_far_end_block_error_saturate: assert property ( // [R10]
        st_r.far_end_block_error_cnt == 16'hFFFF && !cnt_read |=> st_r.far_end_block_error_cnt == 16'hFFFF)
        else $error("event counter wrapped");

    a_far_end_block_error_read_clears: assert property ( // [R10]
        cnt_read && !(frame_strobe && frame_far_end_block_error_bits != 3'h7)
        |=> st_r.far_end_block_error_cnt == 16'h0000)
        else $error("event counter not cleared by high-byte read");

    // the interrupt line follows unmasked pending bits with no extra delay
    a_irq_level: assert property ( // [R2] [R6] [R13]
        irq == |(st_r.int_stat & st_r.int_mask))
        else $error("interrupt line disagrees with pending bits");

    // each used interrupt bit is sticky until software touches the register
    for (genvar b = 2; b <= 4; b++)
    begin : g_int_sticky
        a_int_bit_sticky: assert property ( // [R16]
            st_r.int_stat[b] && !(bus_req && bus_idx == `DAM_IDX_INT)
            |=> st_r.int_stat[b])
            else $error("interrupt bit lost without a clear");
    end

    c_idle_declared: cover property ($rose(st_r.idle_flag));
    c_far_end_receive_failure_cycle: cover property ($rose(st_r.far_end_receive_failure_flag) ##[1:50] $fell(st_r.far_end_receive_failure_flag));
    c_far_end_block_error_counted: cover property (frame_strobe && frame_far_end_block_error_bits != 3'h7);
    c_irq_raised: cover property ($rose(irq));
    c_idle_cleared: cover property ($fell(st_r.idle_flag));

endmodule : dam_rx_alarm_monitor

// file: dv/dam_far_end_model.sv
`timescale 1ns/1ps
// remote terminal behind the line unit: one m-frame summary per request
module dam_far_end_model (
    input wire logic clock,
    input wire logic send,
    input wire logic idle_pat,
    input wire logic [1:0] x_set,
    input wire logic blk_err,
    input wire logic application_ident_channel,
    input wire logic [1:0] flaw,
    output logic frame_strobe = 1'h0,
    output logic frame_mfp_valid = 1'h0,
    output logic [2:0] frame_cp_bits = 3'h5,
    output logic [1:0] frame_x_bits = 2'h2,
    output logic frame_payload_1100 = 1'h0,
    output logic [2:0] frame_far_end_block_error_bits = 3'h2,
    output logic frame_aic_bit = 1'h0
);
    // between frames the lines churn so a stale frame never passes for a real one
    always @(posedge clock)
    begin
        frame_strobe <= send;
        if (send)
        begin
            // flaw 1 spoils the framing bits, flaw 2 the cp-bits
            frame_mfp_valid <= (flaw != 2'h1);
            frame_cp_bits <= (flaw == 2'h2) ? 3'h4 : 3'h0;
            frame_x_bits <= x_set;
            frame_payload_1100 <= idle_pat;
            frame_far_end_block_error_bits <= blk_err ? 3'h2 : 3'h7;
            frame_aic_bit <= application_ident_channel;
        end
        else
        begin
            frame_mfp_valid <= ~frame_mfp_valid;
            frame_cp_bits <= ~frame_cp_bits;
            frame_x_bits <= ~frame_x_bits;
            frame_payload_1100 <= ~frame_payload_1100;
            frame_far_end_block_error_bits <= ~frame_far_end_block_error_bits;
            frame_aic_bit <= ~frame_aic_bit;
        end
    end
endmodule : dam_far_end_model

// file: dv/dam_rx_alarm_monitor_bench.sv
`timescale 1ns/1ps
module dam_rx_alarm_monitor_bench;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic cyc = 1'h0, stb = 1'h0, we = 1'h0, send = 1'h0, idle_pat = 1'h0;
    logic blk_err = 1'h0, application_ident_channel = 1'h0, ack, irq, idle_f, far_end_receive_failure_f, fs, fv, fp, fa;
    logic [1:0] x_set = 2'h3;
    logic [1:0] flaw = 2'h0;
    logic [3:0] sel = 4'hF;
    logic [1:0] fx;
    logic [2:0] fc, fe;
    logic [8:0] adr = 9'h000;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic [7:0] rd;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    always #10 clock = ~clock;
    dam_rx_alarm_monitor dam_rx_alarm_monitor_inst (.clock(clock), .reset(reset),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq(irq), .frame_strobe(fs),
        .frame_mfp_valid(fv), .frame_cp_bits(fc), .frame_x_bits(fx),
        .frame_payload_1100(fp), .frame_far_end_block_error_bits(fe), .frame_aic_bit(fa),
        .idle_condition_flag(idle_f), .far_end_fail_flag(far_end_receive_failure_f));
    dam_far_end_model dam_far_end_model_inst (.clock(clock), .send(send),
        .idle_pat(idle_pat), .x_set(x_set), .blk_err(blk_err), .application_ident_channel(application_ident_channel), .flaw(flaw),
        .frame_strobe(fs), .frame_mfp_valid(fv), .frame_cp_bits(fc), .frame_x_bits(fx),
        .frame_payload_1100(fp), .frame_far_end_block_error_bits(fe), .frame_aic_bit(fa));
    task summarize;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    // hang guard, well above the roughly 660 cycles the run needs
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            mismatches++;
            summarize();
        end
    end
    task check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // classic single cycle; the answer latency is left to the slave
    task wb(input logic w, input logic [6:0] idx, input logic [7:0] d);
        @(posedge clock);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= {idx, 2'h0};
        wdat <= {24'h000000, d};
        @(posedge clock);
        while (ack !== 1'h1) @(posedge clock);
        rd = rdat[7:0];
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask : wb
    task rchk(input logic [6:0] idx, input logic [7:0] exp);
        wb(1'h0, idx, 8'h00);
        check(rd, exp);
    endtask : rchk
    task frame(input logic ip, input logic [1:0] x, input logic e, input logic a);
        @(posedge clock);
        send <= 1'h1;
        idle_pat <= ip;
        x_set <= x;
        blk_err <= e;
        application_ident_channel <= a;
        @(posedge clock);
        send <= 1'h0;
        repeat (2) @(posedge clock);
    endtask : frame
    task t_regs;
        rchk(7'h11, 8'h00);
        rchk(7'h13, 8'h00);
        rchk(7'h20, 8'h00);
        wb(1'h1, 7'h11, 8'hFF);
        rchk(7'h11, 8'h00);
        wb(1'h1, 7'h10, 8'hFF);
        rchk(7'h10, 8'h0F);
        wb(1'h1, 7'h1A, 8'hFF);
        rchk(7'h1A, 8'h1C);
        sel <= 4'hE;
        wb(1'h1, 7'h1A, 8'h00);
        rchk(7'h1A, 8'h1C);
        sel <= 4'hF;
        rchk(7'h58, 8'h00);
    endtask : t_regs
    task t_aic;
        frame(1'h0, 2'h3, 1'h0, 1'h1);
        check({7'h00, irq}, 8'h01);
        rchk(7'h11, 8'h0F);
        rchk(7'h13, 8'h04);
        rchk(7'h13, 8'h00);
        frame(1'h0, 2'h3, 1'h0, 1'h0);
        rchk(7'h11, 8'h07);
        wb(1'h1, 7'h13, 8'h04);
        rchk(7'h13, 8'h00);
        @(posedge clock);
        check({7'h00, irq}, 8'h00);
        frame(1'h0, 2'h3, 1'h0, 1'h0);
        rchk(7'h13, 8'h00);
        frame(1'h0, 2'h3, 1'h0, 1'h1);
        rchk(7'h13, 8'h04);
    endtask : t_aic
    task t_far_end_receive_failure;
        frame(1'h0, 2'h0, 1'h0, 1'h1);
        check({7'h00, far_end_receive_failure_f}, 8'h01);
        frame(1'h0, 2'h1, 1'h0, 1'h1);
        rchk(7'h11, 8'h1F);
        rchk(7'h13, 8'h08);
        frame(1'h0, 2'h3, 1'h0, 1'h1);
        check({7'h00, far_end_receive_failure_f}, 8'h00);
        rchk(7'h13, 8'h08);
    endtask : t_far_end_receive_failure
    task t_far_end_block_error;
        repeat (3) frame(1'h0, 2'h3, 1'h1, 1'h1);
        rchk(7'h11, 8'h0A);
        frame(1'h0, 2'h3, 1'h0, 1'h1);
        rchk(7'h58, 8'h00);
        rchk(7'h59, 8'h03);
        rchk(7'h58, 8'h00);
        rchk(7'h59, 8'h00);
    endtask : t_far_end_block_error
    // two extra idle frames prove the counter stops at its ceiling
    task t_idle;
        repeat (62) frame(1'h1, 2'h3, 1'h0, 1'h1);
        check({7'h00, idle_f}, 8'h00);
        frame(1'h1, 2'h3, 1'h0, 1'h1);
        check({7'h00, idle_f}, 8'h01);
        rchk(7'h10, 8'h2F);
        rchk(7'h13, 8'h10);
        repeat (2) frame(1'h1, 2'h3, 1'h0, 1'h1);
        repeat (20) frame(1'h1, 2'h1, 1'h0, 1'h1);
        flaw <= 2'h1;
        repeat (21) frame(1'h1, 2'h3, 1'h0, 1'h1);
        flaw <= 2'h2;
        repeat (21) frame(1'h1, 2'h3, 1'h0, 1'h1);
        flaw <= 2'h0;
        check({7'h00, idle_f}, 8'h01);
        frame(1'h0, 2'h3, 1'h0, 1'h1);
        check({7'h00, idle_f}, 8'h00);
        rchk(7'h13, 8'h10);
    endtask : t_idle
    initial
    begin
        repeat (4) @(posedge clock);
        reset <= 1'h0;
        @(posedge clock);
        t_regs();
        t_aic();
        t_far_end_receive_failure();
        t_far_end_block_error();
        t_idle();
        summarize();
    end
endmodule : dam_rx_alarm_monitor_bench
